// ===== design/mdc_pkg.sv
// Shared constants and types of the MAC DMA transmit/receive control block.
package mdc_pkg;

  // ==========================================================================
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] TXC_OFS = 4'h0;
  localparam logic [3:0] RXC_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'hC;

  // ==========================================================================
  // Reset values and writable-bit masks; reserved bits stay zero.
  localparam logic [31:0] TXC_RESET = 32'h0000_0000;
  localparam logic [31:0] RXC_RESET = 32'h0000_0000;
  localparam logic [31:0] TXC_WMASK = 32'h3F07_0207;
  localparam logic [31:0] RXC_WMASK = 32'h3F08_0001;

  // ==========================================================================
  // Field positions.
  localparam int BURST_LSB = 24;
  localparam int BURST_W = 6;
  localparam int CSUM_BIT = 16;
  localparam int FC_BIT = 9;
  localparam int PAD_BIT = 2;
  localparam int CRC_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int ALIGN_BIT = 19;

  // ==========================================================================
  // Frame, buffer and flow control figures.
  localparam int LEN_W = 12;
  localparam logic [LEN_W-1:0] MIN_FRAME_BYTES = 12'h040;
  localparam logic [LEN_W-1:0] PAUSE_THRESH = 12'hC00;
  localparam logic [1:0] IP_ALIGN_SHIFT = 2'h2;

  // ==========================================================================
  // Run state of one DMA direction.
  typedef enum logic [2:0] {
    RUN_STOPPED = 3'b001,
    RUN_RUNNING = 3'b010,
    RUN_DRAINING = 3'b100
  } mdc_run_t;

endpackage

// ===== design/mdc_run_ctrl.sv
// Run/stop sequencer for one DMA direction.
`timescale 1ns/1ns
`default_nettype none
module mdc_run_ctrl
  import mdc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // Control and frame events.
  input wire logic enable_i,
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  // State.
  output logic running_o,
  output mdc_run_t state_o
);

  typedef struct packed {
    mdc_run_t state;
    logic in_frame;
    logic running;
  } mdc_rc_t;

  mdc_rc_t s_q, s_d;
  logic busy;

  // A frame only opens while running; an end closes it even while draining.
  always_comb begin
    s_d = s_q;
    busy = (s_q.in_frame | (frame_start_i & s_q.running)) & ~frame_end_i;
    s_d.in_frame = busy;
    case (s_q.state)
      RUN_STOPPED: begin
        if (enable_i) s_d.state = RUN_RUNNING; // [R9] [R19]
      end
      RUN_RUNNING: begin
        if (!enable_i) s_d.state = busy ? RUN_DRAINING : RUN_STOPPED; // [R10] [R11] [R19]
      end
      RUN_DRAINING: begin
        if (enable_i) s_d.state = RUN_RUNNING;
        else if (!busy) s_d.state = RUN_STOPPED; // [R10] [R19]
      end
      default: s_d.state = RUN_STOPPED;
    endcase
    s_d.running = (s_d.state == RUN_RUNNING);
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) s_q <= '{state: RUN_STOPPED, in_frame: 1'b0, running: 1'b0};
    else s_q <= s_d;
  end

  assign running_o = s_q.running;
  assign state_o = s_q.state;

  // A stop never cuts a frame short.
  a_stop_waits_frame: assert property (@(posedge mclk_i) disable iff (reset_i) // [R10]
    (s_q.state == RUN_DRAINING && !frame_end_i && !enable_i) |=> s_q.state == RUN_DRAINING)
    else $error("draining direction stopped before its frame ended");

endmodule // mdc_run_ctrl
`default_nettype wire

// ===== design/mdc_burst.sv
// Burst length grant and word counter for one DMA direction.
`timescale 1ns/1ns
`default_nettype none
module mdc_burst
  import mdc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // Transaction events.
  input wire logic start_i,
  input wire logic word_i,
  input wire logic [BURST_W-1:0] limit_i,
  input wire logic [LEN_W-1:0] level_i,
  // Grant.
  output logic [LEN_W-1:0] len_o,
  output logic busy_o
);

  typedef struct packed {
    logic busy;
    logic [LEN_W-1:0] left;
    logic [LEN_W-1:0] len;
  } mdc_bs_t;

  mdc_bs_t s_q, s_d;
  logic [LEN_W-1:0] cap;

  // The grant is the buffered data, cut to the limit when one is set.
  always_comb begin
    s_d = s_q;
    cap = {{(LEN_W-BURST_W){1'b0}}, limit_i};
    if (start_i && !s_q.busy) begin
      s_d.len = (limit_i == '0 || level_i < cap) ? level_i : cap; // [R12] [R13] [R18]
      s_d.left = s_d.len;
      s_d.busy = (s_d.len != '0);
    end else if (word_i && s_q.busy) begin
      s_d.left = s_q.left - 12'h001;
      s_d.busy = (s_q.left != 12'h001);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) s_q <= '0;
    else s_q <= s_d;
  end

  assign len_o = s_q.len;
  assign busy_o = s_q.busy;

endmodule // mdc_burst
`default_nettype wire

// ===== design/mdc_top.sv
// MAC DMA transmit/receive control: registers, modes, flow control, run/stop.
//
// What this block does
// R1: Checksum-generate bit makes the transmitter insert correct IP header checksums.
// R2: Software should also turn on CRC append when it turns on checksums.
// R3: Full duplex with flow control: send PAUSE when receive buffer nears overflow.
// R4: Half duplex with flow control: apply back-pressure instead of PAUSE frames.
// R5: Flow control bit clear: neither PAUSE nor back-pressure is ever produced.
// R6: Padding on: frames shorter than 64 bytes are padded up to 64.
// R7: Padding on forces CRC append on, whatever the CRC bit says.
// R8: CRC bit set: the frame CRC is appended to every transmitted frame.
// R9: Setting transmit enable starts the transmit DMA running.
// R10: Clearing transmit enable stops only after the current frame completes.
// R11: A stop request only acts while the transmit process is running.
// R12: Receive burst size caps the words moved per receive DMA transaction.
// R13: Receive burst size zero: burst bounded only by buffered receive data.
// R14: Software programs burst sizes only as 0, 1, 2, 4, 8, 16 or 32.
// R15: IP alignment on shifts received frames so the IP header is word aligned.
// R16: The layer-2 header shift is reported for receive descriptor word zero.
// R17: Software should write the receive control register late in initialisation.
// R18: Transmit burst size caps words per transmit transaction; zero is unlimited.
// R19: Receive enable runs receive DMA; clearing stops after the current frame.
// R20: The PAUSE trigger level is a fixed constant with room for in-flight frames.
// R21: Reserved bits of both control registers read as zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module mdc_top
  import mdc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Port mode and receive buffer level.
  input wire logic full_duplex_i,
  input wire logic [LEN_W-1:0] rx_buf_level_i,
  // Transmit frame and DMA events.
  input wire logic tx_frame_start_i,
  input wire logic tx_frame_end_i,
  input wire logic [LEN_W-1:0] tx_frame_len_i,
  input wire logic tx_xact_start_i,
  input wire logic tx_word_i,
  input wire logic [LEN_W-1:0] tx_buf_level_i,
  // Transmit controls.
  output logic tx_running_o,
  output logic tx_ip_csum_o,
  output logic tx_crc_o,
  output logic tx_pad_o,
  output logic [6:0] tx_pad_bytes_o,
  output logic [LEN_W-1:0] tx_burst_len_o,
  output logic tx_burst_busy_o,
  output logic pause_req_o,
  output logic backpressure_o,
  // Receive frame and DMA events.
  input wire logic rx_frame_start_i,
  input wire logic rx_frame_end_i,
  input wire logic rx_xact_start_i,
  input wire logic rx_word_i,
  // Receive controls.
  output logic rx_running_o,
  output logic rx_ip_align_o,
  output logic [1:0] rx_l2_shift_o,
  output logic [LEN_W-1:0] rx_burst_len_o,
  output logic rx_burst_busy_o
);

  // ==========================================================================
  // State

  typedef struct packed {
    logic [31:0] txc;
    logic [31:0] rxc;
    logic wait_n;
    logic [31:0] rdata;
    logic above;
    logic pause;
    logic bp;
    logic csum;
    logic crc;
    logic pad;
    logic [6:0] pad_bytes;
    logic align;
    logic [1:0] shift;
  } mdc_top_t;

  mdc_top_t s_q, s_d;
  mdc_run_t tx_state, rx_state;
  logic [31:0] status;
  logic req;
  logic [LEN_W-1:0] pad_fill;

  // Byte-lane merge; only writable bits survive the mask.
  function automatic logic [31:0] mdc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) m[8*b +: 8] = wd[8*b +: 8];
    end
    return m & mask; // [R21]
  endfunction

  // ==========================================================================
  // Next-state logic

  assign req = avs_read_i | avs_write_i;
  assign status = {20'h00000, backpressure_o, pause_req_o, 2'h0, 1'b0, rx_state, 1'b0, tx_state};
  assign pad_fill = MIN_FRAME_BYTES - tx_frame_len_i;

  // The slave answers one cycle after a request, with waitrequest low for one
  // cycle; writes land on the edge that closes that low cycle, so the master sees
  // them only once it has been released.
  always_comb begin
    s_d = s_q;
    s_d.wait_n = 1'b0;
    if (req && !s_q.wait_n) begin
      s_d.wait_n = 1'b1;
      case (avs_address_i)
        TXC_OFS: s_d.rdata = s_q.txc;
        RXC_OFS: s_d.rdata = s_q.rxc;
        STAT_OFS: s_d.rdata = status;
        default: s_d.rdata = 32'h0000_0000;
      endcase
      if (!avs_read_i) s_d.rdata = 32'h0000_0000;
    end
    if (avs_write_i && s_q.wait_n) begin
      case (avs_address_i)
        TXC_OFS: s_d.txc = mdc_merge(s_q.txc, avs_writedata_i, avs_byteenable_i, TXC_WMASK);
        RXC_OFS: s_d.rxc = mdc_merge(s_q.rxc, avs_writedata_i, avs_byteenable_i, RXC_WMASK);
        default: s_d.txc = s_q.txc;
      endcase
    end

    // Transmit modes follow the register one cycle later.
    s_d.csum = s_q.txc[CSUM_BIT]; // [R1]
    s_d.pad = s_q.txc[PAD_BIT]; // [R6]
    s_d.crc = s_q.txc[CRC_BIT] | s_q.txc[PAD_BIT]; // [R7] [R8]

    // Pad length is taken at frame start, so a mid-frame write cannot tear it.
    if (tx_frame_start_i) begin
      if (s_q.txc[PAD_BIT] && tx_frame_len_i < MIN_FRAME_BYTES) begin
        s_d.pad_bytes = pad_fill[6:0]; // [R6]
      end else begin
        s_d.pad_bytes = 7'h00;
      end
    end

    // Flow control: PAUSE once per crossing, back-pressure while above.
    s_d.above = (rx_buf_level_i >= PAUSE_THRESH); // [R20]
    s_d.pause = s_q.txc[FC_BIT] & full_duplex_i & s_d.above & ~s_q.above; // [R3] [R5]
    s_d.bp = s_q.txc[FC_BIT] & ~full_duplex_i & s_d.above; // [R4] [R5]

    // Receive alignment shift is frozen per frame for its descriptor.
    s_d.align = s_q.rxc[ALIGN_BIT]; // [R15]
    if (rx_frame_start_i) begin
      s_d.shift = s_q.rxc[ALIGN_BIT] ? IP_ALIGN_SHIFT : 2'h0; // [R15] [R16]
    end
  end

  // ==========================================================================
  // Registers

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.txc <= TXC_RESET;
      s_q.rxc <= RXC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Direction sequencers and burst counters

  mdc_run_ctrl u_tx_run (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .enable_i(s_q.txc[EN_BIT]),
    .frame_start_i(tx_frame_start_i),
    .frame_end_i(tx_frame_end_i),
    .running_o(tx_running_o),
    .state_o(tx_state)
  );

  mdc_run_ctrl u_rx_run (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .enable_i(s_q.rxc[EN_BIT]),
    .frame_start_i(rx_frame_start_i),
    .frame_end_i(rx_frame_end_i),
    .running_o(rx_running_o),
    .state_o(rx_state)
  );

  // Odd burst codes are not rejected; the limiter just uses them as counts.
  mdc_burst u_tx_burst (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .start_i(tx_xact_start_i),
    .word_i(tx_word_i),
    .limit_i(s_q.txc[BURST_LSB +: BURST_W]),
    .level_i(tx_buf_level_i),
    .len_o(tx_burst_len_o),
    .busy_o(tx_burst_busy_o)
  );

  mdc_burst u_rx_burst (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .start_i(rx_xact_start_i),
    .word_i(rx_word_i),
    .limit_i(s_q.rxc[BURST_LSB +: BURST_W]),
    .level_i(rx_buf_level_i),
    .len_o(rx_burst_len_o),
    .busy_o(rx_burst_busy_o)
  );

  // ==========================================================================
  // Outputs, each straight from a register

  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = ~s_q.wait_n;
  assign tx_ip_csum_o = s_q.csum;
  assign tx_crc_o = s_q.crc;
  assign tx_pad_o = s_q.pad;
  assign tx_pad_bytes_o = s_q.pad_bytes;
  assign pause_req_o = s_q.pause;
  assign backpressure_o = s_q.bp;
  assign rx_ip_align_o = s_q.align;
  assign rx_l2_shift_o = s_q.shift;

  // ==========================================================================
  // Checks

  a_crc_forced_pad: assert property (@(posedge mclk_i) disable iff (reset_i) // [R7]
    s_q.txc[PAD_BIT] |=> tx_crc_o) else $error("padding did not force CRC append");

  a_csum_follows_bit: assert property (@(posedge mclk_i) disable iff (reset_i) // [R1]
    ##1 tx_ip_csum_o == $past(s_q.txc[CSUM_BIT]))
    else $error("checksum enable does not follow its bit");

  a_pause_full_dup: assert property (@(posedge mclk_i) disable iff (reset_i) // [R3]
    pause_req_o |-> $past(full_duplex_i) && $past(s_q.txc[FC_BIT]) && !backpressure_o)
    else $error("pause sent without full duplex flow control");

  a_pause_one_pulse: assert property (@(posedge mclk_i) disable iff (reset_i) // [R3]
    pause_req_o |=> !pause_req_o) else $error("pause request held longer than a cycle");

  a_bp_half_dup: assert property (@(posedge mclk_i) disable iff (reset_i) // [R4]
    backpressure_o |-> !$past(full_duplex_i) && $past(rx_buf_level_i) >= PAUSE_THRESH)
    else $error("back-pressure outside half duplex overflow risk");

  a_no_flow_ctrl: assert property (@(posedge mclk_i) disable iff (reset_i) // [R5]
    !s_q.txc[FC_BIT] |=> !pause_req_o && !backpressure_o)
    else $error("flow control acted while disabled");

  a_pad_to_min: assert property (@(posedge mclk_i) disable iff (reset_i) // [R6]
    (tx_frame_start_i && s_q.txc[PAD_BIT] && tx_frame_len_i < MIN_FRAME_BYTES)
    |=> tx_pad_bytes_o == 7'(MIN_FRAME_BYTES - $past(tx_frame_len_i)))
    else $error("short frame not padded to minimum");

  a_rx_shift_rep: assert property (@(posedge mclk_i) disable iff (reset_i) // [R16]
    rx_frame_start_i |=> rx_l2_shift_o == ($past(s_q.rxc[ALIGN_BIT]) ? IP_ALIGN_SHIFT : 2'h0))
    else $error("layer-2 shift does not match alignment");

  a_rsvd_read_zero: assert property (@(posedge mclk_i) disable iff (reset_i) // [R21]
    ((s_q.txc & ~TXC_WMASK) == '0) && ((s_q.rxc & ~RXC_WMASK) == '0))
    else $error("reserved control bits became nonzero");

  a_burst_capped: assert property (@(posedge mclk_i) disable iff (reset_i) // [R12]
    (rx_xact_start_i && !rx_burst_busy_o && s_q.rxc[BURST_LSB +: BURST_W] != '0)
    |=> rx_burst_len_o <= 12'($past(s_q.rxc[BURST_LSB +: BURST_W])))
    else $error("receive burst exceeds programmed size");

  // A zero size code must not cut the grant; only the buffered data bounds it.
  a_rx_burst_whole: assert property (@(posedge mclk_i) disable iff (reset_i) // [R13]
    (rx_xact_start_i && !rx_burst_busy_o && s_q.rxc[BURST_LSB +: BURST_W] == '0)
    |=> rx_burst_len_o == $past(rx_buf_level_i))
    else $error("unlimited receive burst not bounded by buffer level");

  a_tx_burst_capped: assert property (@(posedge mclk_i) disable iff (reset_i) // [R18]
    (tx_xact_start_i && !tx_burst_busy_o && s_q.txc[BURST_LSB +: BURST_W] != '0)
    |=> tx_burst_len_o <= 12'($past(s_q.txc[BURST_LSB +: BURST_W])))
    else $error("transmit burst exceeds programmed size");

  a_tx_run_start: assert property (@(posedge mclk_i) disable iff (reset_i) // [R9]
    (tx_state == RUN_STOPPED && s_q.txc[EN_BIT]) |=> tx_running_o)
    else $error("transmit enable did not start the process");

  a_rx_run_start: assert property (@(posedge mclk_i) disable iff (reset_i) // [R19]
    (rx_state == RUN_STOPPED && s_q.rxc[EN_BIT]) |=> rx_running_o)
    else $error("receive enable did not start the process");

  a_bus_answers: assert property (@(posedge mclk_i) disable iff (reset_i)
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus request not answered in one cycle");

endmodule // mdc_top
`default_nettype wire

// ===== verification/mdc_link_model.sv
// Behavioural model of the MAC side: frame events and DMA word pulses.
`timescale 1ns/1ns
`default_nettype none
module mdc_link_model (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // Commands from the bench and burst state from the block.
  input wire logic go_i,
  input wire logic [7:0] hold_i,
  input wire logic slow_i,
  input wire logic busy_i,
  // Frame and word events.
  output logic frame_start_o,
  output logic frame_end_o,
  output logic word_o
);
  logic [7:0] cnt_q;
  logic open_q;

  // ==========================================================================
  // Frame sequencing and word pacing.
  // A slow partner moves a word only every other cycle, which stretches bursts.
  always_ff @(posedge mclk_i) begin
    frame_start_o <= 1'h0;
    frame_end_o <= 1'h0;
    word_o <= busy_i & (~slow_i | ~word_o);
    if (reset_i) begin
      open_q <= 1'h0;
      cnt_q <= 8'h00;
      word_o <= 1'h0;
    end else if (go_i && !open_q) begin
      frame_start_o <= 1'h1;
      open_q <= 1'h1;
      cnt_q <= hold_i;
    end else if (open_q) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h00) begin
        frame_end_o <= 1'h1;
        open_q <= 1'h0;
      end
    end
  end
endmodule // mdc_link_model
`default_nettype wire

// ===== verification/mdc_top_bench.sv
// Self-checking testbench of the MAC DMA transmit/receive control block.
`timescale 1ns/1ns
`default_nettype none
module mdc_top_bench;
  import mdc_pkg::*;
  logic mclk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic full_duplex_i = 1'h1;
  logic [LEN_W-1:0] rx_lvl = 12'h0, tx_lvl = 12'h0, tx_len = 12'h0;
  logic [1:0] go = 2'h0, slow = 2'h0, xs = 2'h0;
  logic [7:0] hold = 8'h04;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, tx_running_o, tx_ip_csum_o, tx_crc_o, tx_pad_o;
  logic pause_req_o, backpressure_o, rx_running_o, rx_ip_align_o;
  logic [6:0] tx_pad_bytes_o;
  logic [1:0] rx_l2_shift_o, fs, fe, wd, busy;
  logic [LEN_W-1:0] tx_burst_len_o, rx_burst_len_o;
  int fails = 0;
  int n_checks = 0;
  // Table rows: write value or limit, level or length, expected result.
  localparam logic [31:0] MW [4] = '{32'h2, 32'h4, 32'h6, 32'h10002};
  localparam logic [2:0] ME [4] = '{3'h2, 3'h3, 3'h3, 3'h6};
  localparam logic [31:0] PW [5] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h1};
  localparam logic [11:0] PL [5] = '{12'h14, 12'h3F, 12'h40, 12'h5EE, 12'h14};
  localparam logic [6:0] PE [5] = '{7'h2C, 7'h01, 7'h00, 7'h00, 7'h00};
  localparam logic [5:0] BL [6] = '{6'h04, 6'h20, 6'h00, 6'h00, 6'h01, 6'h10};
  localparam logic [11:0] BV [6] = '{12'h00A, 12'h007, 12'h005, 12'h009, 12'h028, 12'h00C};

  // ==========================================================================
  // Clock, design and the two partner models.
  always #5 mclk_i = ~mclk_i;
  mdc_top u_mdc_top (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .full_duplex_i(full_duplex_i),
    .rx_buf_level_i(rx_lvl), .tx_frame_start_i(fs[0]), .tx_frame_end_i(fe[0]),
    .tx_frame_len_i(tx_len), .tx_xact_start_i(xs[0]), .tx_word_i(wd[0]),
    .tx_buf_level_i(tx_lvl), .tx_running_o(tx_running_o), .tx_ip_csum_o(tx_ip_csum_o),
    .tx_crc_o(tx_crc_o), .tx_pad_o(tx_pad_o), .tx_pad_bytes_o(tx_pad_bytes_o),
    .tx_burst_len_o(tx_burst_len_o), .tx_burst_busy_o(busy[0]), .pause_req_o(pause_req_o),
    .backpressure_o(backpressure_o), .rx_frame_start_i(fs[1]), .rx_frame_end_i(fe[1]),
    .rx_xact_start_i(xs[1]), .rx_word_i(wd[1]), .rx_running_o(rx_running_o),
    .rx_ip_align_o(rx_ip_align_o), .rx_l2_shift_o(rx_l2_shift_o),
    .rx_burst_len_o(rx_burst_len_o), .rx_burst_busy_o(busy[1]));
  mdc_link_model u_tx_link (.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go[0]), .hold_i(hold),
    .slow_i(slow[0]), .busy_i(busy[0]), .frame_start_o(fs[0]), .frame_end_o(fe[0]),
    .word_o(wd[0]));
  mdc_link_model u_rx_link (.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go[1]), .hold_i(hold),
    .slow_i(slow[1]), .busy_i(busy[1]), .frame_start_o(fs[1]), .frame_end_o(fe[1]),
    .word_o(wd[1]));

  // ==========================================================================
  // Shared tasks: verdict, comparison and Avalon-MM cycles.
  task end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // One idle edge first, so a release is never overwritten in the same step.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    if (n >= 50) begin
      fails++;
      end_of_test();
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    check(q & m, exp);
  endtask
  // Starts one frame on a direction and, when wait_end is set, waits, bounded, for it to close.
  task frame(input int d, input logic [7:0] h, input bit wait_end);
    int n;
    hold <= h;
    go[d] <= 1'h1;
    tick(1);
    go[d] <= 1'h0;
    for (n = 0; n < 300 && wait_end && fe[d] !== 1'h1; n++) tick(1);
    if (n >= 300) begin
      fails++;
      end_of_test();
    end
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [3:0] a;
    int w;
    int n;
    tick(6);
    reset_i <= 1'h0;
    tick(1);
    rd(TXC_OFS, 32'hFFFF_FFFF, 32'h0);
    rd(RXC_OFS, 32'hFFFF_FFFF, 32'h0);
    rd(STAT_OFS, 32'hFFFF_FFFF, 32'h11);
    // Reserved bits and an unmapped address.
    wr(TXC_OFS, 32'hFFFF_FFFF);
    rd(TXC_OFS, 32'hFFFF_FFFF, 32'h3F07_0207);
    wr(RXC_OFS, 32'hFFFF_FFFF);
    rd(RXC_OFS, 32'hFFFF_FFFF, 32'h3F08_0001);
    wr(4'h8, 32'hFFFF_FFFF);
    rd(4'h8, 32'hFFFF_FFFF, 32'h0);
    wr(TXC_OFS, 32'h0);
    // Only the top byte lane is written; the other lanes keep their zeros.
    avs_byteenable_i <= 4'h8;
    wr(TXC_OFS, 32'hFFFF_FFFF);
    avs_byteenable_i <= 4'hF;
    rd(TXC_OFS, 32'hFFFF_FFFF, 32'h3F00_0000);
    wr(RXC_OFS, 32'h0);
    // Mode bits; checksum generation always goes with CRC append.
    for (int i = 0; i < 4; i++) begin
      wr(TXC_OFS, MW[i]);
      tick(4);
      check(32'({tx_ip_csum_o, tx_crc_o, tx_pad_o}), 32'(ME[i]));
    end
    // Padding of short frames, then with padding off.
    for (int i = 0; i < 5; i++) begin
      wr(TXC_OFS, PW[i]);
      tx_len <= PL[i];
      tick(3);
      frame(0, 8'h04, 1'b1);
      check(32'(tx_pad_bytes_o), 32'(PE[i]));
    end
    // Run, drain on stop, ignored stop while stopped, both directions.
    for (int d = 0; d < 2; d++) begin
      a = (d == 1) ? RXC_OFS : TXC_OFS;
      wr(a, 32'h1);
      tick(3);
      check(32'((d == 1) ? rx_running_o : tx_running_o), 32'h1);
      frame(d, 8'h28, 1'b0);
      tick(2);
      wr(a, 32'h0);
      tick(2);
      rd(STAT_OFS, 32'h7 << (4 * d), 32'h4 << (4 * d));
      frame(d, 8'h00, 1'b1);
      tick(3);
      rd(STAT_OFS, 32'h7 << (4 * d), 32'h1 << (4 * d));
      wr(a, 32'h0);
      tick(3);
      rd(STAT_OFS, 32'h7 << (4 * d), 32'h1 << (4 * d));
      check(32'((d == 1) ? rx_running_o : tx_running_o), 32'h0);
    end
    // Flow control: full duplex pause, half duplex back-pressure, disabled.
    for (int i = 0; i < 4; i++) begin
      wr(TXC_OFS, (i < 2) ? 32'h200 : 32'h0);
      full_duplex_i <= ~i[0];
      rx_lvl <= PAUSE_THRESH - 12'h001;
      tick(4);
      w = 0;
      rx_lvl <= PAUSE_THRESH;
      repeat (6) begin
        tick(1);
        w += int'(pause_req_o);
      end
      check(32'(w), (i == 0) ? 32'h1 : 32'h0);
      check(32'(backpressure_o), (i == 1) ? 32'h1 : 32'h0);
      rx_lvl <= 12'h0;
    end
    // Bursts with legal size codes only, alternating direction; the middle two run at slow pace.
    for (int i = 0; i < 6; i++) begin
      a = i[0] ? TXC_OFS : RXC_OFS;
      wr(a, 32'(BL[i]) << 24);
      rx_lvl <= BV[i];
      tx_lvl <= BV[i];
      slow <= {2{i[1]}};
      tick(1);
      xs[~i[0]] <= 1'h1;
      tick(1);
      xs <= 2'h0;
      tick(1);
      w = (BL[i] == 6'h00 || BV[i] < 12'(BL[i])) ? int'(BV[i]) : int'(BL[i]);
      check(32'(i[0] ? tx_burst_len_o : rx_burst_len_o), 32'(w));
      n = 0;
      for (int k = 0; k < 400 && busy[~i[0]] === 1'h1; k++) begin
        n += int'(wd[~i[0]]);
        tick(1);
      end
      if (busy[~i[0]] === 1'h1) begin
        fails++;
        end_of_test();
      end
      check(32'(n), 32'(w));
    end
    // IP header alignment; receive control is written last in this set-up.
    wr(RXC_OFS, 32'h0008_0001);
    tick(3);
    check(32'(rx_ip_align_o), 32'h1);
    frame(1, 8'h04, 1'b1);
    check(32'(rx_l2_shift_o), 32'h2);
    wr(RXC_OFS, 32'h1);
    tick(3);
    frame(1, 8'h04, 1'b1);
    check(32'({rx_ip_align_o, rx_l2_shift_o}), 32'h0);
    end_of_test();
  end
endmodule // mdc_top_bench
`default_nettype wire
